// file: oec_host_model.sv
`timescale 1ns/1ps

// Remote host plus the external shutdown, protect-loop and trigger sources.
module oec_host_model (
   input wire logic clk_i,
   output oec_pkg::oec_cmd_type cmd_o,
   output logic trigger_o,
   output logic shutdown_o,
   output logic loop_o
);
   // An unconnected trigger line floats high, so the idle level is one.
   initial begin
      cmd_o = '0;
      trigger_o = 1'h1;
      shutdown_o = 1'h0;
      loop_o = 1'h1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Commands are one-cycle pulses and the bus idles at zero.
   task automatic send(input logic [2:0] code, input logic [1:0] arg);
      @(posedge clk_i);
      cmd_o <= '{1'h1, code, arg};
      @(posedge clk_i);
      cmd_o <= '0;
   endtask : send
   // Level stays put afterwards; pulse mode relies on the caller restoring it.
   task automatic trig(input logic v, input int n);
      @(posedge clk_i);
      trigger_o <= v;
      repeat (n) @(posedge clk_i);
      // Returning just after the edge lets callers read settled outputs.
      #1;
   endtask : trig
   // Holds shutdown active, or the loop open, for n cycles, then releases it.
   task automatic fault(input logic loop, input int n);
      @(posedge clk_i);
      if (loop) loop_o <= 1'h0;
      else shutdown_o <= 1'h1;
      repeat (n) @(posedge clk_i);
      loop_o <= 1'h1;
      shutdown_o <= 1'h0;
   endtask : fault
endmodule : oec_host_model

// file: oec_limit_scale.sv
`timescale 1ns/1ps

module oec_limit_scale (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [13:0] mv_i,
   output logic [15:0] prot_o
);

   localparam logic [13:0] SPAN_MV = oec_pkg::EXT_HI_MV - oec_pkg::EXT_LO_MV;
   localparam logic [15:0] SPAN_OUT = oec_pkg::PROT_MAX - oec_pkg::PROT_MIN;

   logic [13:0] clamp_mv;
   logic [29:0] prod;
   logic [15:0] prot_nxt;

   // Inputs outside the span clamp to its ends rather than wrap.
   always_comb begin
      clamp_mv = mv_i;
      if (mv_i < oec_pkg::EXT_LO_MV) begin
         clamp_mv = oec_pkg::EXT_LO_MV;
      end else if (mv_i > oec_pkg::EXT_HI_MV) begin
         clamp_mv = oec_pkg::EXT_HI_MV;
      end
      prod = 30'(clamp_mv - oec_pkg::EXT_LO_MV) * 30'(SPAN_OUT);
      prot_nxt = oec_pkg::PROT_MIN + 16'(prod / 30'(SPAN_MV));
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         prot_o <= oec_pkg::PROT_MIN;
      end else begin
         prot_o <= prot_nxt;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   scale_low_end_a: assert property (mv_i <= oec_pkg::EXT_LO_MV |=> prot_o == oec_pkg::PROT_MIN)
      else $error("Low analog limit did not map to ten percent.");
   scale_high_end_a: assert property (mv_i >= oec_pkg::EXT_HI_MV |=> prot_o == oec_pkg::PROT_MAX)
      else $error("High analog limit did not map to maximum.");

endmodule : oec_limit_scale

// file: oec_pkg.sv
package oec_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing.
   localparam int CLK_MHZ = 250;
   localparam int SHUTDOWN_MIN_US = 100;
   localparam int PULSE_MIN_US = 100;
   localparam int TRIG_OFF_MAX_MS = 200;
   localparam int SHUTDOWN_MIN_CYC = SHUTDOWN_MIN_US * CLK_MHZ;
   localparam int PULSE_MIN_CYC = PULSE_MIN_US * CLK_MHZ;
   localparam int TRIG_OFF_MAX_CYC = TRIG_OFF_MAX_MS * 1000 * CLK_MHZ;

   ////////////////////////////////////////////////////////////////////////////////
   // Strap fields and analog limit scaling.
   localparam int STRAP_TRIG_POL_BIT = 4;
   localparam logic [13:0] EXT_LO_MV = 14'h03e8;
   localparam logic [13:0] EXT_HI_MV = 14'h2710;
   localparam logic [15:0] PROT_MAX = 16'hffff;
   localparam logic [15:0] PROT_MIN = 16'h199a;
   localparam logic [15:0] PROT_MIN_BOX = 16'h0148;
   localparam logic [15:0] ZERO_REF = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////////
   // Encodings.
   typedef enum logic [2:0] {
      CTRL_LEVEL = 3'b001,
      CTRL_PULSE_OFF = 3'b010,
      CTRL_TRIG_IGNORED = 3'b100
   } oec_ctrl_type;

   typedef enum logic [2:0] {
      LOAD_ACTIVE = 3'b001,
      LOAD_RESISTIVE = 3'b010,
      LOAD_BATTERY = 3'b100
   } oec_load_type;

   typedef enum logic [2:0] {
      ST_OFF = 3'b001,
      ST_ON = 3'b010,
      ST_SHUTDOWN = 3'b100
   } oec_state_type;

   localparam logic [2:0] CMD_OUTPUT_ON = 3'h1;
   localparam logic [2:0] CMD_OUTPUT_OFF = 3'h2;
   localparam logic [2:0] CMD_CTRL_SET = 3'h3;
   localparam logic [2:0] CMD_SAVE_INTERNAL = 3'h4;
   localparam logic [2:0] CMD_LOAD_SELECT = 3'h5;

   localparam logic [1:0] ARG_CTRL_LEVEL = 2'h0;
   localparam logic [1:0] ARG_CTRL_PULSE_OFF = 2'h1;
   localparam logic [1:0] ARG_CTRL_TRIG_IGNORED = 2'h2;
   localparam logic [1:0] ARG_LOAD_ACTIVE = 2'h0;
   localparam logic [1:0] ARG_LOAD_RESISTIVE = 2'h1;
   localparam logic [1:0] ARG_LOAD_BATTERY = 2'h2;

   typedef struct packed {
      logic valid;
      logic [2:0] code;
      logic [1:0] arg;
   } oec_cmd_type;

   typedef struct packed {
      logic curr_mode;
      logic [15:0] main_ref;
      logic [15:0] protect;
      logic [15:0] limit;
   } oec_setpt_type;

endpackage : oec_pkg

// file: oec_qualify.sv
`timescale 1ns/1ps

module oec_qualify #(
   parameter int CYC = 25000,
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic in_i,
   output logic stable_o,
   output logic rise_o,
   output logic fall_o
);

   localparam int CW = $clog2(CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(CYC - 1);

   logic [CW-1:0] cnt_r, cnt_nxt;
   logic stable_nxt, rise_nxt, fall_nxt;

   // A change is accepted only after CYC consecutive differing samples, so shorter glitches vanish.
   always_comb begin
      cnt_nxt = '0;
      stable_nxt = stable_o;
      rise_nxt = 1'b0;
      fall_nxt = 1'b0;
      if (in_i != stable_o) begin
         if (cnt_r == LAST) begin
            stable_nxt = in_i;
            rise_nxt = in_i;
            fall_nxt = ~in_i;
         end else begin
            cnt_nxt = cnt_r + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cnt_r <= '0;
         stable_o <= RESET_VAL;
         rise_o <= 1'b0;
         fall_o <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         stable_o <= stable_nxt;
         rise_o <= rise_nxt;
         fall_o <= fall_nxt;
      end
   end

endmodule : oec_qualify

// file: oec_top.sv
`timescale 1ns/1ps

// How it works
// - Shutdown held 100 us stops both stages.
// - Shutdown latches until power cycle only.
// - Latched: logic alive, no output, fault red.
// - Open protect loop shuts down when enabled.
// - Default polarity: high or open disables output.
// - Default polarity: low or short enables output.
// - Trigger polarity chosen by power-up switch.
// - Pulse-off mode: 100 us low disables.
// - Pulse-off mode: high level changes nothing.
// - Output-on command enables; pulse mode needs it.
// - Trigger-ignored setting leaves commands in control.
// - Otherwise trigger level overrides host commands.
// - Save command stores control setting; restored.
// - Disabled output applies load-type off settings.
// - Analog limits scale onto the protection channel.
// - Active off: voltage mode, zero, limits max.
// - Active re-enable restores prior settings.
// - Battery off: current mode, calibrated zero.
module oec_top #(
   parameter int SHUTDOWN_QUAL_CYC = oec_pkg::SHUTDOWN_MIN_CYC,
   parameter int TRIG_QUAL_CYC = oec_pkg::PULSE_MIN_CYC
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [4:0] power_up_switch_bank_i,
   input wire logic nv_ctrl_valid_i,
   input wire logic [1:0] nv_ctrl_i,
   input wire logic shutdown_i,
   input wire logic chained_protect_loop_i,
   input wire logic cable_disconnect_en_i,
   input wire logic trigger_i,
   input wire oec_pkg::oec_cmd_type cmd_i,
   input wire oec_pkg::oec_setpt_type user_set_i,
   input wire logic [15:0] cal_zero_current_i,
   input wire logic ext_limit_en_i,
   input wire logic [13:0] ext_limit_mv_i,
   output logic output_en_o,
   output logic output_led_o,
   output logic power_stage_en_o,
   output logic power_fault_indicator_o,
   output oec_pkg::oec_setpt_type applied_o,
   output oec_pkg::oec_ctrl_type ctrl_setting_o,
   output oec_pkg::oec_load_type load_type_o,
   output logic nv_save_o,
   output logic [1:0] nv_save_ctrl_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers.
   function automatic logic f_cmd(input oec_pkg::oec_cmd_type c, input logic [2:0] code);
      f_cmd = c.valid && (c.code == code);
   endfunction : f_cmd

   function automatic oec_pkg::oec_ctrl_type f_ctrl_dec(input logic [1:0] arg);
      case (arg)
         oec_pkg::ARG_CTRL_PULSE_OFF: f_ctrl_dec = oec_pkg::CTRL_PULSE_OFF;
         oec_pkg::ARG_CTRL_TRIG_IGNORED: f_ctrl_dec = oec_pkg::CTRL_TRIG_IGNORED;
         default: f_ctrl_dec = oec_pkg::CTRL_LEVEL;
      endcase
   endfunction : f_ctrl_dec

   function automatic logic [1:0] f_ctrl_enc(input oec_pkg::oec_ctrl_type c);
      case (c)
         oec_pkg::CTRL_PULSE_OFF: f_ctrl_enc = oec_pkg::ARG_CTRL_PULSE_OFF;
         oec_pkg::CTRL_TRIG_IGNORED: f_ctrl_enc = oec_pkg::ARG_CTRL_TRIG_IGNORED;
         default: f_ctrl_enc = oec_pkg::ARG_CTRL_LEVEL;
      endcase
   endfunction : f_ctrl_enc

   ////////////////////////////////////////////////////////////////////////////////
   // Input qualification.
   logic shut_q, loop_lost_q, trig_q, trig_fall;
   logic [15:0] ext_prot;

   oec_qualify #(.CYC(SHUTDOWN_QUAL_CYC), .RESET_VAL(1'b0)) u_shut_q (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .in_i(shutdown_i),
      .stable_o(shut_q),
      .rise_o(),
      .fall_o()
   );

   oec_qualify #(.CYC(SHUTDOWN_QUAL_CYC), .RESET_VAL(1'b0)) u_loop_q (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .in_i(~chained_protect_loop_i),
      .stable_o(loop_lost_q),
      .rise_o(),
      .fall_o()
   );

   // The open-circuit level reads as high, so the trigger rests in its off state under the default polarity.
   oec_qualify #(.CYC(TRIG_QUAL_CYC), .RESET_VAL(1'b1)) u_trig_q (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .in_i(trigger_i),
      .stable_o(trig_q),
      .rise_o(),
      .fall_o(trig_fall)
   );

   oec_limit_scale u_limit (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .mv_i(ext_limit_mv_i),
      .prot_o(ext_prot)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Enable state.
   oec_pkg::oec_state_type state_r, state_nxt;
   oec_pkg::oec_ctrl_type ctrl_nxt;
   oec_pkg::oec_load_type load_nxt;
   oec_pkg::oec_setpt_type applied_nxt;
   logic boot_r, pol_r, pol_nxt, save_nxt;
   logic [1:0] save_ctrl_nxt;
   logic fault_src, trig_on, on_cmd, off_cmd;

   always_comb begin
      on_cmd = f_cmd(cmd_i, oec_pkg::CMD_OUTPUT_ON);
      off_cmd = f_cmd(cmd_i, oec_pkg::CMD_OUTPUT_OFF);
      fault_src = shut_q || (cable_disconnect_en_i && loop_lost_q);
      trig_on = pol_r ? trig_q : ~trig_q;
      state_nxt = state_r;
      ctrl_nxt = ctrl_setting_o;
      load_nxt = load_type_o;
      pol_nxt = pol_r;
      save_nxt = 1'b0;
      save_ctrl_nxt = nv_save_ctrl_o;
      if (!boot_r) begin
         // Straps and the saved setting are caught on the first edge after reset release.
         pol_nxt = power_up_switch_bank_i[oec_pkg::STRAP_TRIG_POL_BIT];
         ctrl_nxt = nv_ctrl_valid_i ? f_ctrl_dec(nv_ctrl_i) : oec_pkg::CTRL_LEVEL;
      end else begin
         if (f_cmd(cmd_i, oec_pkg::CMD_CTRL_SET)) begin
            ctrl_nxt = f_ctrl_dec(cmd_i.arg);
         end
         if (f_cmd(cmd_i, oec_pkg::CMD_SAVE_INTERNAL)) begin
            save_nxt = 1'b1;
            save_ctrl_nxt = f_ctrl_enc(ctrl_setting_o);
         end
         if (f_cmd(cmd_i, oec_pkg::CMD_LOAD_SELECT)) begin
            case (cmd_i.arg)
               oec_pkg::ARG_LOAD_RESISTIVE: load_nxt = oec_pkg::LOAD_RESISTIVE;
               oec_pkg::ARG_LOAD_BATTERY: load_nxt = oec_pkg::LOAD_BATTERY;
               default: load_nxt = oec_pkg::LOAD_ACTIVE;
            endcase
         end
         case (state_r)
            oec_pkg::ST_SHUTDOWN: begin
               state_nxt = oec_pkg::ST_SHUTDOWN;
            end
            oec_pkg::ST_OFF, oec_pkg::ST_ON: begin
               if (fault_src) begin
                  state_nxt = oec_pkg::ST_SHUTDOWN;
               end else begin
                  case (ctrl_setting_o)
                     oec_pkg::CTRL_PULSE_OFF: begin
                        // A qualified low pulse wins over an on command in the same cycle.
                        if (trig_fall) begin
                           state_nxt = oec_pkg::ST_OFF;
                        end else if (on_cmd) begin
                           state_nxt = oec_pkg::ST_ON;
                        end else if (off_cmd) begin
                           state_nxt = oec_pkg::ST_OFF;
                        end
                     end
                     oec_pkg::CTRL_TRIG_IGNORED: begin
                        if (on_cmd) begin
                           state_nxt = oec_pkg::ST_ON;
                        end else if (off_cmd) begin
                           state_nxt = oec_pkg::ST_OFF;
                        end
                     end
                     default: begin
                        state_nxt = trig_on ? oec_pkg::ST_ON : oec_pkg::ST_OFF;
                     end
                  endcase
               end
            end
            default: state_nxt = oec_pkg::ST_OFF;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Applied setpoints.
   // The stored user settings are never overwritten while off, so re-enable simply reselects them.
   always_comb begin
      applied_nxt = user_set_i;
      if (ext_limit_en_i) begin
         applied_nxt.protect = ext_prot;
      end
      if (state_nxt != oec_pkg::ST_ON) begin
         case (load_nxt)
            oec_pkg::LOAD_BATTERY: begin
               applied_nxt.curr_mode = 1'b1;
               applied_nxt.main_ref = cal_zero_current_i;
               applied_nxt.protect = oec_pkg::PROT_MAX;
               applied_nxt.limit = oec_pkg::PROT_MAX;
            end
            oec_pkg::LOAD_RESISTIVE: begin
               applied_nxt.main_ref = oec_pkg::ZERO_REF;
               applied_nxt.protect = oec_pkg::PROT_MIN_BOX;
               applied_nxt.limit = oec_pkg::PROT_MAX;
            end
            default: begin
               applied_nxt.curr_mode = 1'b0;
               applied_nxt.main_ref = oec_pkg::ZERO_REF;
               applied_nxt.protect = oec_pkg::PROT_MAX;
               applied_nxt.limit = oec_pkg::PROT_MAX;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_r <= oec_pkg::ST_OFF;
         boot_r <= 1'b0;
         pol_r <= 1'b0;
         ctrl_setting_o <= oec_pkg::CTRL_LEVEL;
         load_type_o <= oec_pkg::LOAD_ACTIVE;
         output_en_o <= 1'b0;
         output_led_o <= 1'b0;
         power_stage_en_o <= 1'b0;
         power_fault_indicator_o <= 1'b0;
         applied_o <= '0;
         nv_save_o <= 1'b0;
         nv_save_ctrl_o <= oec_pkg::ARG_CTRL_LEVEL;
      end else begin
         state_r <= state_nxt;
         boot_r <= 1'b1;
         pol_r <= pol_nxt;
         ctrl_setting_o <= ctrl_nxt;
         load_type_o <= load_nxt;
         output_en_o <= (state_nxt == oec_pkg::ST_ON);
         output_led_o <= (state_nxt == oec_pkg::ST_ON);
         power_stage_en_o <= boot_r && (state_nxt != oec_pkg::ST_SHUTDOWN);
         power_fault_indicator_o <= (state_nxt == oec_pkg::ST_SHUTDOWN);
         applied_o <= applied_nxt;
         nv_save_o <= save_nxt;
         nv_save_ctrl_o <= save_ctrl_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   logic live;
   assign live = boot_r && (state_r != oec_pkg::ST_SHUTDOWN) && !fault_src;

   shut_entry_a: assert property (boot_r && shut_q |=> state_r == oec_pkg::ST_SHUTDOWN && !power_stage_en_o)
      else $error("Qualified shutdown did not stop the power stages.");
   latch_hold_a: assert property (state_r == oec_pkg::ST_SHUTDOWN |=> state_r == oec_pkg::ST_SHUTDOWN)
      else $error("Shutdown latch released without power cycle.");
   shut_outputs_a: assert property (state_r == oec_pkg::ST_SHUTDOWN |-> !output_en_o && power_fault_indicator_o)
      else $error("Latched shutdown shows output or no fault.");
   loop_loss_a: assert property (boot_r && cable_disconnect_en_i && loop_lost_q |=> power_fault_indicator_o)
      else $error("Open protect loop did not shut down.");
   level_off_a: assert property (live && ctrl_setting_o == oec_pkg::CTRL_LEVEL && !pol_r && trig_q
      |=> !output_en_o && !output_led_o)
      else $error("High trigger did not disable output.");
   level_on_a: assert property (live && ctrl_setting_o == oec_pkg::CTRL_LEVEL && !pol_r && !trig_q
      |=> output_en_o && output_led_o)
      else $error("Low trigger did not enable output.");
   pol_inv_a: assert property (live && ctrl_setting_o == oec_pkg::CTRL_LEVEL && pol_r && trig_q ##1 !off_cmd
      |-> output_en_o)
      else $error("Inverted polarity not honoured.");
   pulse_off_a: assert property (live && ctrl_setting_o == oec_pkg::CTRL_PULSE_OFF && trig_fall |=> !output_en_o)
      else $error("Qualified low pulse did not disable output.");
   pulse_high_a: assert property (live && ctrl_setting_o == oec_pkg::CTRL_PULSE_OFF && !trig_fall && !on_cmd
      && !off_cmd |=> $stable(output_en_o))
      else $error("Trigger level changed output in pulse-off mode.");
   on_cmd_a: assert property (live && ctrl_setting_o != oec_pkg::CTRL_LEVEL && on_cmd && !trig_fall
      |=> output_en_o)
      else $error("Output-on command did not enable output.");
   ignored_a: assert property (live && ctrl_setting_o == oec_pkg::CTRL_TRIG_IGNORED && !on_cmd && !off_cmd
      |=> $stable(output_en_o))
      else $error("Trigger acted while ignored.");
   level_wins_a: assert property (live && ctrl_setting_o == oec_pkg::CTRL_LEVEL && on_cmd && !trig_on
      |=> !output_en_o)
      else $error("Host command overrode trigger level.");
   save_a: assert property (boot_r && f_cmd(cmd_i, oec_pkg::CMD_SAVE_INTERNAL)
      |=> nv_save_o && nv_save_ctrl_o == f_ctrl_enc($past(ctrl_setting_o)))
      else $error("Save did not store the control setting.");
   active_off_a: assert property (!output_en_o && load_type_o == oec_pkg::LOAD_ACTIVE && boot_r ##0 $past(boot_r)
      |-> !applied_o.curr_mode && applied_o.main_ref == oec_pkg::ZERO_REF
      && applied_o.protect == oec_pkg::PROT_MAX && applied_o.limit == oec_pkg::PROT_MAX)
      else $error("Active off-state settings wrong.");
   restore_a: assert property (output_en_o && !$past(ext_limit_en_i)
      |-> applied_o == $past(user_set_i))
      else $error("Enabled output does not reflect prior settings.");
   ext_prot_a: assert property (output_en_o && $past(ext_limit_en_i)
      |-> applied_o.protect == $past(ext_prot) && applied_o.limit == $past(user_set_i.limit))
      else $error("Analog limit not applied to protection only.");
   battery_off_a: assert property (!output_en_o && load_type_o == oec_pkg::LOAD_BATTERY
      |-> applied_o.curr_mode && applied_o.main_ref == $past(cal_zero_current_i)
      && applied_o.protect == oec_pkg::PROT_MAX)
      else $error("Battery off-state settings wrong.");
   shut_priority_a: assert property (state_r == oec_pkg::ST_SHUTDOWN && on_cmd |=> !output_en_o)
      else $error("Command enabled output during shutdown.");

endmodule : oec_top

// file: output_enable_control_tb_top.sv
`timescale 1ns/1ps

module output_enable_control_tb_top;
   localparam int N = 8;
   localparam oec_pkg::oec_setpt_type US = '{1'h0, 16'h1234, 16'h4321, 16'h5678};
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [4:0] strap = 5'h00;
   logic nv_v = 1'h0;
   logic [1:0] nv_c = 2'h0;
   logic cde = 1'h0;
   logic ext_en = 1'h0;
   logic [13:0] ext_mv = 14'h03e8;
   logic [15:0] cal = 16'h0011;
   logic trg, shd, lp, en, led, pse, flt, nvs;
   logic [1:0] nvc;
   oec_pkg::oec_cmd_type cmd;
   oec_pkg::oec_setpt_type app;
   oec_pkg::oec_ctrl_type ctrl;
   oec_pkg::oec_load_type load;
   int n_fail = 0;
   int compares = 0;

   always #2 clk = ~clk;

   oec_host_model host (.clk_i(clk), .cmd_o(cmd), .trigger_o(trg), .shutdown_o(shd), .loop_o(lp));

   // Short qualification counts keep the run brief; the qualification waits derive from N.
   oec_top #(.SHUTDOWN_QUAL_CYC(N), .TRIG_QUAL_CYC(N)) dut (
      .clk_i(clk), .reset_i(rst), .power_up_switch_bank_i(strap), .nv_ctrl_valid_i(nv_v),
      .nv_ctrl_i(nv_c), .shutdown_i(shd), .chained_protect_loop_i(lp), .cable_disconnect_en_i(cde),
      .trigger_i(trg), .cmd_i(cmd), .user_set_i(US), .cal_zero_current_i(cal),
      .ext_limit_en_i(ext_en), .ext_limit_mv_i(ext_mv), .output_en_o(en), .output_led_o(led),
      .power_stage_en_o(pse), .power_fault_indicator_o(flt), .applied_o(app),
      .ctrl_setting_o(ctrl), .load_type_o(load), .nv_save_o(nvs), .nv_save_ctrl_o(nvc));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [48:0] seen, input logic [48:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic w(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : w

   task automatic boot(input logic [4:0] s, input logic v, input logic [1:0] c);
      @(posedge clk);
      strap <= s;
      nv_v <= v;
      nv_c <= c;
      rst <= 1'h1;
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      w(3);
   endtask : boot

   task automatic results;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results

   initial begin
      #200000;
      n_fail++;
      results();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      boot(5'h00, 1'h0, 2'h0);
      chk("ctrl", 49'(ctrl), 49'(3'h1));
      chk("pse", 49'(pse), 49'(1'h1));
      chk("en", 49'(en), 49'(1'h0));
      host.trig(1'h0, N + 4);
      chk("en", 49'(en), 49'(1'h1));
      chk("led", 49'(led), 49'(1'h1));
      chk("app", 49'(app), 49'(US));
      host.send(oec_pkg::CMD_OUTPUT_OFF, 2'h0);
      w(2);
      chk("en", 49'(en), 49'(1'h1));
      host.trig(1'h1, N + 4);
      chk("led", 49'(led), 49'(1'h0));
      chk("app", 49'(app), 49'({1'h0, oec_pkg::ZERO_REF, oec_pkg::PROT_MAX, oec_pkg::PROT_MAX}));
      host.send(oec_pkg::CMD_OUTPUT_ON, 2'h0);
      w(2);
      chk("en", 49'(en), 49'(1'h0));
      // Host-only control: trigger swings must not matter.
      host.send(oec_pkg::CMD_CTRL_SET, oec_pkg::ARG_CTRL_TRIG_IGNORED);
      host.send(oec_pkg::CMD_OUTPUT_ON, 2'h0);
      w(1);
      chk("en", 49'(en), 49'(1'h1));
      host.trig(1'h0, N + 4);
      host.trig(1'h1, N + 4);
      chk("en", 49'(en), 49'(1'h1));
      host.send(oec_pkg::CMD_SAVE_INTERNAL, 2'h0);
      #1;
      chk("nvs", 49'(nvs), 49'(1'h1));
      chk("nvc", 49'(nvc), 49'(oec_pkg::ARG_CTRL_TRIG_IGNORED));
      w(1);
      chk("nvs", 49'(nvs), 49'(1'h0));
      host.send(oec_pkg::CMD_OUTPUT_OFF, 2'h0);
      host.send(oec_pkg::CMD_LOAD_SELECT, oec_pkg::ARG_LOAD_BATTERY);
      w(1);
      chk("load", 49'(load), 49'(3'h4));
      chk("app", 49'(app), 49'({1'h1, cal, oec_pkg::PROT_MAX, oec_pkg::PROT_MAX}));
      host.send(oec_pkg::CMD_LOAD_SELECT, oec_pkg::ARG_LOAD_RESISTIVE);
      w(1);
      chk("app", 49'(app), 49'({US.curr_mode, oec_pkg::ZERO_REF, oec_pkg::PROT_MIN_BOX, oec_pkg::PROT_MAX}));
      // Pulse-off mode: only a long low pulse turns off, only the host turns on.
      host.send(oec_pkg::CMD_CTRL_SET, oec_pkg::ARG_CTRL_PULSE_OFF);
      host.send(oec_pkg::CMD_LOAD_SELECT, oec_pkg::ARG_LOAD_ACTIVE);
      host.send(oec_pkg::CMD_OUTPUT_ON, 2'h0);
      w(N + 4);
      chk("en", 49'(en), 49'(1'h1));
      host.trig(1'h0, N - 2);
      host.trig(1'h1, N + 4);
      chk("en", 49'(en), 49'(1'h1));
      host.trig(1'h0, N);
      host.trig(1'h1, N + 4);
      chk("en", 49'(en), 49'(1'h0));
      host.send(oec_pkg::CMD_OUTPUT_ON, 2'h0);
      w(1);
      chk("en", 49'(en), 49'(1'h1));
      // Analog limits map onto the protect span, with both ends, the midpoint and a clamp below the low end checked.
      @(posedge clk);
      ext_en <= 1'h1;
      w(N);
      chk("prot", 49'(app.protect), 49'(oec_pkg::PROT_MIN));
      @(posedge clk);
      ext_mv <= 14'h2710;
      w(N);
      chk("prot", 49'(app.protect), 49'(oec_pkg::PROT_MAX));
      @(posedge clk);
      ext_mv <= 14'h157c;
      w(N);
      chk("prot", 49'(app.protect), 49'(oec_pkg::PROT_MIN + ((oec_pkg::PROT_MAX - oec_pkg::PROT_MIN) >> 4'h1)));
      @(posedge clk);
      ext_mv <= 14'h01f4;
      w(N);
      chk("prot", 49'(app.protect), 49'(oec_pkg::PROT_MIN));
      @(posedge clk);
      ext_en <= 1'h0;
      host.fault(1'h1, N + 4);
      // The first opening comes while cable_disconnect_en_i is low, so only the second opening can trip.
      w(N + 2);
      chk("flt", 49'(flt), 49'(1'h0));
      @(posedge clk);
      cde <= 1'h1;
      host.fault(1'h1, N + 4);
      w(2);
      chk("flt", 49'(flt), 49'(1'h1));
      // Restart with a restored setting, then a remote shutdown.
      @(posedge clk);
      cde <= 1'h0;
      boot(5'h00, 1'h1, oec_pkg::ARG_CTRL_TRIG_IGNORED);
      chk("ctrl", 49'(ctrl), 49'(3'h4));
      chk("flt", 49'(flt), 49'(1'h0));
      host.send(oec_pkg::CMD_OUTPUT_ON, 2'h0);
      host.fault(1'h0, N - 2);
      w(4);
      chk("en", 49'(en), 49'(1'h1));
      host.fault(1'h0, N);
      w(3);
      chk("pse", 49'(pse), 49'(1'h0));
      chk("flt", 49'(flt), 49'(1'h1));
      chk("en", 49'(en), 49'(1'h0));
      host.send(oec_pkg::CMD_OUTPUT_ON, 2'h0);
      w(N);
      chk("en", 49'(en), 49'(1'h0));
      chk("led", 49'(led), 49'(1'h0));
      // Inverted trigger polarity from the power-up switches.
      boot(5'h10, 1'h0, 2'h0);
      w(N + 4);
      chk("en", 49'(en), 49'(1'h1));
      host.trig(1'h0, N + 4);
      chk("en", 49'(en), 49'(1'h0));
      results();
   end
endmodule : output_enable_control_tb_top
